// ===== rtl/window_irq.v
// Purpose : Window-comparator interrupt for a six-channel light sensor
// Assumes : Register port is driven on i_clk by the serial bus logic; results arrive on i_clk
// Notes   : Low limit updates atomically through a low-byte holding latch; high limit bytes take effect at once
`timescale 1ns/100ps
`include "window_irq_regs.vh"

// Notes on behaviour
// RULE1: Selected channel's 16-bit result is compared to a low and high limit.
// RULE2: With enable set, interrupt only after persistence-many consecutive outside results. Code needs the setting plus one.
// RULE3: Low limit is built from a low-byte and a high-byte register.
// RULE4: High limit is built from a low-byte and a high-byte register.
// RULE5: Result below low limit counts toward persistence, then raises the interrupt.
// RULE6: Result above high limit counts toward persistence, then raises the interrupt.
// RULE7: Written low-limit low byte waits in a latch; active limit keeps old byte.
// RULE8: High-byte write loads latched low byte and new high byte together.
// RULE9: Host writes both low-limit bytes within one bus transaction.
// RULE10: Three-bit channel select picks channel zero to five; resets to zero.
// RULE11: With enable set, a met window event sets the status interrupt flag.
// RULE12: Separate read-only flags record above-high or below-low as the cause.
// RULE13: Writing one clears a status flag, zero leaves it; set beats clear.
// RULE14: Window evaluated once per measurement; inside result resets the count.
module window_irq
(
   input  wire         i_clk,
   input  wire         i_reset,
   input  wire         i_reg_write,
   input  wire         i_reg_read,
   input  wire [7:0]   i_reg_addr,
   input  wire [7:0]   i_reg_wdata,
   output reg  [7:0]   o_reg_rdata,
   input  wire         i_result_valid,
   input  wire [95:0]  i_channel_results,
   output wire         o_irq
);
   reg  [7:0]  low_lo_hold_ff;
   reg  [15:0] low_limit_ff;
   reg  [7:0]  high_lo_ff;
   reg  [7:0]  high_hi_ff;
   reg  [2:0]  chan_sel_ff;
   reg  [3:0]  persist_ff;
   reg         irq_enable_ff;
   reg         window_flag_ff;
   reg         above_flag_ff;
   reg         below_flag_ff;
   reg  [15:0] result_ff;
   reg         sample_ff;
   reg  [15:0] selected_result;
   reg  [7:0]  nxt_rdata;
   wire [15:0] channel_result [0:`NUM_CHANNELS-1];
   wire [15:0] high_limit;
   wire        below;
   wire        above;
   wire        outside;
   wire        met;
   wire        event_set;
   wire        clear_window;
   wire        wr_low_lo;
   wire        wr_low_hi;
   wire        wr_high_lo;
   wire        wr_high_hi;
   wire        wr_chan_sel;
   wire        wr_persist;
   wire        wr_irq_enable;
   genvar      g;

   function wr_hit;
      input [7:0] addr;
      begin
         wr_hit = i_reg_write && (i_reg_addr == addr);
      end
   endfunction

   // Puts one flag at its bit position in an otherwise empty byte
   function [7:0] place_bit;
      input integer pos;
      input         val;
      begin
         place_bit      = 8'h00;
         place_bit[pos] = val;
      end
   endfunction

   assign wr_low_lo     = wr_hit(`ADDR_LOW_LIMIT_LO);
   assign wr_low_hi     = wr_hit(`ADDR_LOW_LIMIT_HI);
   assign wr_high_lo    = wr_hit(`ADDR_HIGH_LIMIT_LO);
   assign wr_high_hi    = wr_hit(`ADDR_HIGH_LIMIT_HI);
   assign wr_chan_sel   = wr_hit(`ADDR_CHANNEL_CONFIG);
   assign wr_persist    = wr_hit(`ADDR_PERSIST);
   assign wr_irq_enable = wr_hit(`ADDR_IRQ_ENABLE);

   assign high_limit = {high_hi_ff, high_lo_ff}; // see RULE4
   assign outside    = below | above; // see RULE5 see RULE6

   // Channel k sits at bits 16k upward of the result bus
   generate
      for (g = 0; g < `NUM_CHANNELS; g = g + 1)
      begin : g_lane
         assign channel_result[g] = i_channel_results[16*g +: 16];
      end
   endgenerate

   // Codes six and seven name no channel and fall back to channel zero
   always @*
   begin
      selected_result = channel_result[0];
      case (chan_sel_ff) // see RULE10
         3'h0: selected_result = channel_result[0];
         3'h1: selected_result = channel_result[1];
         3'h2: selected_result = channel_result[2];
         3'h3: selected_result = channel_result[3];
         3'h4: selected_result = channel_result[4];
         3'h5: selected_result = channel_result[5];
         default: selected_result = channel_result[0];
      endcase
   end

   // The result is captured so a select change mid-measurement never reaches the compare
   always @(posedge i_clk)
   begin
      if (i_reset)
      begin
         sample_ff <= 1'h0;
      end
      else
      begin
         sample_ff <= i_result_valid; // see RULE14
      end
   end

   always @(posedge i_clk)
   begin
      if (i_reset)
      begin
         result_ff <= 16'h0000;
      end
      else if (i_result_valid)
      begin
         result_ff <= selected_result; // see RULE1
      end
   end

   window_compare u_compare
   (
      .i_result     (result_ff),
      .i_low_limit  (low_limit_ff),
      .i_high_limit (high_limit),
      .o_below      (below),
      .o_above      (above)
   ); // see RULE1

   persistence_counter u_persist
   (
      .i_clk               (i_clk),
      .i_reset             (i_reset),
      .i_sample            (sample_ff),
      .i_outside           (outside),
      .i_persistence_count (persist_ff),
      .o_met               (met)
   ); // see RULE5 see RULE6 see RULE14

   assign event_set    = met & irq_enable_ff; // see RULE2 see RULE11
   assign clear_window = wr_hit(`ADDR_STATUS) & i_reg_wdata[`STATUS_WINDOW_BIT];
   assign o_irq        = window_flag_ff;

   // Low byte waits here so the active limit never holds a mixed value
   always @(posedge i_clk)
   begin
      if (i_reset)
      begin
         low_lo_hold_ff <= `LIMIT_RESET;
      end
      else if (wr_low_lo)
      begin
         low_lo_hold_ff <= i_reg_wdata; // see RULE7
      end
   end

   // Both bytes land at one edge; a lone high-byte write reuses the held byte
   always @(posedge i_clk)
   begin
      if (i_reset)
      begin
         low_limit_ff <= {`LIMIT_RESET, `LIMIT_RESET};
      end
      else if (wr_low_hi)
      begin
         low_limit_ff <= {i_reg_wdata, low_lo_hold_ff}; // see RULE3 see RULE8
      end
   end

   // The high limit has no holding latch, so each byte takes effect at once
   always @(posedge i_clk)
   begin
      if (i_reset)
      begin
         high_lo_ff <= `LIMIT_RESET;
      end
      else if (wr_high_lo)
      begin
         high_lo_ff <= i_reg_wdata; // see RULE4
      end
   end

   always @(posedge i_clk)
   begin
      if (i_reset)
      begin
         high_hi_ff <= `LIMIT_RESET;
      end
      else if (wr_high_hi)
      begin
         high_hi_ff <= i_reg_wdata; // see RULE4
      end
   end

   always @(posedge i_clk)
   begin
      if (i_reset)
      begin
         chan_sel_ff <= `CHAN_SEL_RESET;
      end
      else if (wr_chan_sel)
      begin
         chan_sel_ff <= i_reg_wdata[`CHAN_SEL_MSB:`CHAN_SEL_LSB]; // see RULE10
      end
   end

   // Four bits only; settings above fifteen cannot be expressed
   always @(posedge i_clk)
   begin
      if (i_reset)
      begin
         persist_ff <= `PERSIST_RESET;
      end
      else if (wr_persist)
      begin
         persist_ff <= i_reg_wdata[`PERSIST_MSB:0];
      end
   end

   // Disabling stops new flags but leaves a pending flag for the host to clear
   always @(posedge i_clk)
   begin
      if (i_reset)
      begin
         irq_enable_ff <= 1'h0;
      end
      else if (wr_irq_enable)
      begin
         irq_enable_ff <= i_reg_wdata[`IRQ_ENABLE_BIT];
      end
   end

   // Set beats clear so an event in the clearing cycle is never lost
   always @(posedge i_clk)
   begin
      if (i_reset)
         window_flag_ff <= 1'h0;
      else if (event_set)
         window_flag_ff <= 1'h1; // see RULE11 see RULE13
      else if (clear_window)
         window_flag_ff <= 1'h0; // see RULE13
   end

   // Cause bits follow the latest event and share the window flag's clear
   always @(posedge i_clk)
   begin
      if (i_reset)
      begin
         above_flag_ff <= 1'h0;
         below_flag_ff <= 1'h0;
      end
      else if (event_set)
      begin
         above_flag_ff <= above; // see RULE12
         below_flag_ff <= below; // see RULE12
      end
      else if (clear_window)
      begin
         above_flag_ff <= 1'h0;
         below_flag_ff <= 1'h0;
      end
   end

   // Low-byte readback shows the held byte, which is what the host last wrote
   always @*
   begin
      nxt_rdata = 8'h00;
      case (i_reg_addr)
         `ADDR_PART_ID:        nxt_rdata = `PART_ID_VALUE;
         `ADDR_CHANNEL_CONFIG: nxt_rdata = {5'h00, chan_sel_ff};
         `ADDR_LOW_LIMIT_LO:   nxt_rdata = low_lo_hold_ff;
         `ADDR_LOW_LIMIT_HI:   nxt_rdata = low_limit_ff[15:8];
         `ADDR_HIGH_LIMIT_LO:  nxt_rdata = high_lo_ff;
         `ADDR_HIGH_LIMIT_HI:  nxt_rdata = high_hi_ff;
         `ADDR_PERSIST:        nxt_rdata = {4'h0, persist_ff};
         `ADDR_IRQ_ENABLE:     nxt_rdata = place_bit(`IRQ_ENABLE_BIT, irq_enable_ff);
         `ADDR_STATUS:         nxt_rdata = place_bit(`STATUS_WINDOW_BIT, window_flag_ff);
         `ADDR_STATUS3:        nxt_rdata = place_bit(`STATUS3_HIGH_BIT, above_flag_ff)
                                           | place_bit(`STATUS3_LOW_BIT, below_flag_ff); // see RULE12
         default:              nxt_rdata = 8'h00;
      endcase
   end

   // Read data holds between reads so a slow host can pick it up late
   always @(posedge i_clk)
   begin
      if (i_reset)
         o_reg_rdata <= 8'h00;
      else if (i_reg_read)
         o_reg_rdata <= nxt_rdata;
   end
endmodule // window_irq

// ===== common/window_irq_regs.vh
// Purpose : Register offsets, fields and reset values of the window-comparator interrupt block
// Assumes : Byte-wide register port addressed by an 8-bit offset
// Notes   : Definitions only
`ifndef WINDOW_IRQ_REGS_VH
`define WINDOW_IRQ_REGS_VH

`define ADDR_PART_ID          8'h5A
`define ADDR_CHANNEL_CONFIG   8'h66
`define ADDR_LOW_LIMIT_LO     8'h84
`define ADDR_LOW_LIMIT_HI     8'h85
`define ADDR_HIGH_LIMIT_LO    8'h86
`define ADDR_HIGH_LIMIT_HI    8'h87
`define ADDR_STATUS3          8'h91
`define ADDR_STATUS           8'h93
`define ADDR_PERSIST          8'hBD
`define ADDR_IRQ_ENABLE       8'hF9

// Arbitrary value, not the code of any real part
`define PART_ID_VALUE         8'h3C
`define CHAN_SEL_MSB          2
`define CHAN_SEL_LSB          0
`define CHAN_SEL_RESET        3'h0
`define NUM_CHANNELS          6
`define LIMIT_RESET           8'h00
`define STATUS_WINDOW_BIT     3
`define STATUS3_HIGH_BIT      5
`define STATUS3_LOW_BIT       4
`define PERSIST_MSB           3
`define PERSIST_RESET         4'h0
`define IRQ_ENABLE_BIT        3

`endif

// ===== rtl/window_compare.v
// Purpose : Compares one 16-bit result against a low and a high limit
// Assumes : Limits are unsigned, strict comparisons
// Notes   : Purely combinational
`timescale 1ns/100ps
module window_compare
(
   input  wire [15:0] i_result,
   input  wire [15:0] i_low_limit,
   input  wire [15:0] i_high_limit,
   output wire        o_below,
   output wire        o_above
);
   assign o_below = (i_result < i_low_limit);
   assign o_above = (i_result > i_high_limit);
endmodule // window_compare

// ===== rtl/persistence_counter.v
// Purpose : Counts consecutive out-of-window measurements
// Assumes : One i_sample pulse per completed measurement
// Notes   : o_met pulses on the sample that brings the count to one more than the setting
`timescale 1ns/100ps
module persistence_counter
(
   input  wire       i_clk,
   input  wire       i_reset,
   input  wire       i_sample,
   input  wire       i_outside,
   input  wire [3:0] i_persistence_count,
   output wire       o_met
);
   reg  [4:0] count_ff;
   wire [4:0] nxt_count;
   wire [4:0] target;

   // Setting n asks for n+1 consecutive results, so zero fires on every outside result
   assign target    = {1'h0, i_persistence_count} + 5'h01;
   assign nxt_count = (count_ff == 5'h1F) ? count_ff : count_ff + 5'h01;
   assign o_met     = i_sample & i_outside & (nxt_count == target);

   always @(posedge i_clk)
   begin
      if (i_reset)
         count_ff <= 5'h00;
      else if (i_sample)
      begin
         if (!i_outside)
            count_ff <= 5'h00;
         else if (nxt_count == target)
            count_ff <= 5'h00;
         else
            count_ff <= nxt_count;
      end
   end
endmodule // persistence_counter

// ===== tb/window_irq_props.sv
// Purpose: port checker for window_irq
// Assumes: one clock, synchronous reset
// Notes: enable bit is mirrored here, as it is seen at the ports only through a register read
`timescale 1ns/100ps
module window_irq_props
(
   input wire logic       i_clk,
   input wire logic       i_reset,
   input wire logic       i_reg_write,
   input wire logic       i_reg_read,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic [7:0] o_reg_rdata,
   input wire logic       i_result_valid,
   input wire logic       o_irq
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);
   logic en_ff;
   logic st_wr;
   assign st_wr = i_reg_write && i_reg_addr == 8'h93;
   always @(posedge i_clk)
   begin
      if (i_reset)
         en_ff <= 1'h0;
      else if (i_reg_write && i_reg_addr == 8'hF9)
         en_ff <= i_reg_wdata[3];
   end
   property p_hold; !i_reg_read |=> $stable(o_reg_rdata); endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   property p_unmap; i_reg_read && i_reg_addr == 8'h10 |=> o_reg_rdata == 8'h00; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read");
   property p_back; i_reg_write && i_reg_addr[7:2] == 6'h21 ##1 i_reg_read && $stable(i_reg_addr)
      |=> o_reg_rdata == $past(i_reg_wdata, 2); endproperty
   a_back: assert property (p_back) else $error("limit readback");
   property p_sel; i_reg_write && i_reg_addr == 8'h66 ##1 i_reg_read && $stable(i_reg_addr)
      |=> o_reg_rdata == ($past(i_reg_wdata, 2) & 8'h07); endproperty
   a_sel: assert property (p_sel) else $error("select readback");
   property p_cause; $rose(o_irq) |-> $past(i_result_valid, 2) || $past(i_result_valid, 3); endproperty
   a_cause: assert property (p_cause) else $error("irq without result");
   property p_keep; o_irq && !st_wr |=> o_irq; endproperty
   a_keep: assert property (p_keep) else $error("irq dropped");
   // Results just before the write may legally set the flag again, so they are excluded
   property p_clr; st_wr && i_reg_wdata[3] && !$past(i_result_valid) && !$past(i_result_valid, 2)
      |=> !o_irq; endproperty
   a_clr: assert property (p_clr) else $error("irq not cleared");
   property p_off; !en_ff && !o_irq && !$past(i_result_valid) && !$past(i_result_valid, 2)
      ##1 !en_ff [*3] |=> !o_irq; endproperty
   a_off: assert property (p_off) else $error("irq while disabled");
endmodule // window_irq_props
bind window_irq window_irq_props u_props (.*);

// ===== tb/reg_host.sv
// Purpose: host model on the register port
// Assumes: strobes are taken at the rising edge
// Notes: idle cycles scramble address and data
`timescale 1ns/100ps
module reg_host
(
   input  wire logic  i_clk,
   output logic       o_write,
   output logic       o_read,
   output logic [7:0] o_addr,
   output logic [7:0] o_wdata
);
   initial
   begin
      {o_write, o_read, o_addr, o_wdata} = 18'h00000;
   end
   task acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
      @(negedge i_clk);
      o_write <= w;
      o_read <= r;
      o_addr <= a;
      o_wdata <= d;
   endtask
   task idle();
      acc(1'h0, 1'h0, 8'($urandom), 8'($urandom));
   endtask
   // Both bytes in one burst so a mixed limit is never staged
   task set_low(input logic [15:0] v);
      acc(1'h1, 1'h0, 8'h84, v[7:0]);
      acc(1'h1, 1'h0, 8'h85, v[15:8]);
   endtask
endmodule // reg_host

// ===== tb/spectral_threshold_interrupt_bench.sv
// Purpose: self-checking bench for window_irq
// Assumes: 100 MHz clock, synchronous reset
// Notes: read data is checked by a watcher against queued notes
`timescale 1ns/100ps
`include "window_irq_regs.vh"
module spectral_threshold_interrupt_bench;
   logic        i_clk = 1'h0;
   logic        i_reset = 1'h1;
   logic        valid = 1'h0;
   logic        rd_seen = 1'h0;
   logic [95:0] results = 96'h0;
   logic        wr_s, rd_s;
   logic [7:0]  addr, wdata, rdata;
   wire         irq;
   logic [7:0]  exp_q[$];
   logic [15:0] v;
   int          num_errors = 0, checked = 0, ch = 0, p, k;
   reg_host h (.i_clk(i_clk), .o_write(wr_s), .o_read(rd_s), .o_addr(addr), .o_wdata(wdata));
   window_irq DUT (.i_clk(i_clk), .i_reset(i_reset), .i_reg_write(wr_s), .i_reg_read(rd_s),
      .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_result_valid(valid),
      .i_channel_results(results), .o_irq(irq));
   initial
   begin
      forever #5 i_clk = ~i_clk;
   end
   task chk(input logic [7:0] g, input logic [7:0] e);
      checked++;
      if (g !== e)
      begin
         num_errors++;
         $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task chk_irq(input logic g, input logic e);
      checked++;
      if (g !== e)
      begin
         num_errors++;
         $display("MISMATCH t=%0t irq got %h exp %h", $time, g, e);
      end
   endtask
   task tally_and_finish();
      $display("checked %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   always @(posedge i_clk) rd_seen <= rd_s;
   always @(negedge i_clk)
   begin
      if (rd_seen)
         chk(rdata, exp_q.pop_front());
   end
   task wr(input logic [7:0] a, input logic [7:0] d);
      h.acc(1'h1, 1'h0, a, d);
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      h.acc(1'h0, 1'h1, a, 8'h00);
   endtask
   // Unselected channels sit inside the window, so a wrong select shows as a missing irq
   task meas(input logic [15:0] x);
      h.idle();
      @(negedge i_clk);
      valid <= 1'h1;
      for (k = 0; k < 6; k++) results[16*k +: 16] <= (k == ch) ? x : 16'h4000;
      @(negedge i_clk);
      valid <= 1'h0;
      results <= {3{$urandom}};
   endtask
   task irq_is(input logic e);
      h.idle();
      repeat (2) @(negedge i_clk);
      chk_irq(irq, e);
   endtask
   initial
   begin
      void'($urandom(73));
      repeat (12) @(negedge i_clk);
      i_reset <= 1'h0;
      rd(8'h5A, `PART_ID_VALUE);
      rd(8'h66, 8'h00);
      rd(8'h10, 8'h00);
      for (p = 8'h84; p < 8'h88; p++) rd(8'(p), 8'h00);
      wr(8'hF9, 8'h08);
      wr(8'h86, 8'h00);
      wr(8'h87, 8'h80);
      h.set_low(16'h1000);
      wr(8'h84, 8'hFF);
      rd(8'h84, 8'hFF);
      meas(16'h1000);
      irq_is(1'h0);
      wr(8'h85, 8'h10);
      meas(16'h1000);
      irq_is(1'h1);
      rd(8'h91, 8'h10);
      rd(8'h93, 8'h08);
      wr(8'h93, 8'h00);
      irq_is(1'h1);
      wr(8'h93, 8'h08);
      irq_is(1'h0);
      for (ch = 0; ch < 6; ch++)
      begin
         p = $urandom % 3;
         v = 16'h8001 + 16'($urandom % 32'h7FFE);
         wr(8'h66, 8'(ch));
         rd(8'h66, 8'(ch));
         wr(8'hBD, 8'(p));
         repeat (p) meas(v);
         meas(16'h4000);
         repeat (p) meas(v);
         irq_is(1'h0);
         meas(v);
         irq_is(1'h1);
         rd(8'h91, 8'h20);
         wr(8'h93, 8'h08);
      end
      ch = 0;
      wr(8'hBD, 8'h00);
      wr(8'h66, 8'h07);
      rd(8'h66, 8'h07);
      wr(8'hF9, 8'h00);
      meas(16'h0000);
      irq_is(1'h0);
      wr(8'hF9, 8'h08);
      meas(16'h0000);
      rd(8'h91, 8'h10);
      irq_is(1'h1);
      tally_and_finish();
   end
   initial
   begin
      #200000;
      num_errors++;
      tally_and_finish();
   end
endmodule // spectral_threshold_interrupt_bench
